// ===== swr_pkg.sv
package swr_pkg;

  // frame shape: instruction byte plus data byte
  localparam int         FRAME_BITS     = 16;
  localparam int         BYTE_BITS      = 8;
  localparam logic [3:0] LAST_SLOT      = 4'hf;

  // field positions inside a received pair
  localparam int         OPC_MSB        = 15;
  localparam int         OPC_LSB        = 13;
  localparam int         ADR_MSB        = 12;
  localparam int         ADR_LSB        = 8;

  // opcodes
  localparam logic [2:0] OP_NOP         = 3'h0;
  localparam logic [2:0] OP_CTRL_RD     = 3'h1;
  localparam logic [2:0] OP_CTRL_WR     = 3'h3;
  localparam logic [2:0] OP_ADDR_RD     = 3'h4;
  localparam logic [2:0] OP_ADDR_WR     = 3'h6;
  localparam logic [2:0] OP_CHAIN_TAG   = 3'h7;

  // register addresses
  localparam logic [4:0] ADDR_WIPER_A   = 5'h00;
  localparam logic [4:0] ADDR_WIPER_B   = 5'h01;
  localparam logic [4:0] ADDR_CTRL      = 5'h10;

  // reset values and control field layout
  localparam logic [7:0] WIPER_RESET    = 8'h80;
  localparam logic [7:0] CTRL_RESET     = 8'h40;
  localparam logic [7:0] CTRL_WMASK     = 8'h42;
  localparam int         CTRL_SHUTDOWN_CONTROL_N_BIT  = 6;
  localparam int         CTRL_OTYPE_BIT = 1;

  typedef enum logic [1:0] {ST_IDLE, ST_FRAME, ST_COMMIT} swr_state_e;

  // readback value for an address, zero when unmapped
  function automatic logic [7:0] read_value(
    input logic [4:0] addr,
    input logic [7:0] wiper,
    input logic [7:0] ctrl
  );
    logic [7:0] val;
    val = 8'h00;
    if (addr == ADDR_WIPER_A || addr == ADDR_WIPER_B) begin
      val = wiper;
    end else if (addr == ADDR_CTRL) begin
      val = ctrl & CTRL_WMASK;
    end
    return val;
  endfunction : read_value

endpackage : swr_pkg

// ===== swr_sync.sv
`timescale 1ns/1ps
module swr_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = d;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_reg <= RST_VAL;
      q        <= RST_VAL;
    end else begin
      meta_reg <= meta_next;
      q        <= q_next;
    end
  end

endmodule : swr_sync

// ===== swr_reg_file.sv
`timescale 1ns/1ps
module swr_reg_file (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       wr_en,
  input  wire logic       wr_ctrl,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] wiper_position,
  output logic      [7:0] access_control
);

  logic [7:0] wiper_position_next;
  logic [7:0] access_control_next;

  // one write per commit; reserved control bits stay zero
  always_comb begin
    wiper_position_next = wiper_position;
    access_control_next = access_control;
    if (wr_en && wr_ctrl) begin
      access_control_next = wr_data & swr_pkg::CTRL_WMASK;
    end else if (wr_en) begin
      wiper_position_next = wr_data;
    end
  end

  // power-up preset puts the wiper at mid-scale
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      wiper_position <= swr_pkg::WIPER_RESET;
      access_control <= swr_pkg::CTRL_RESET;
    end else begin
      wiper_position <= wiper_position_next;
      access_control <= access_control_next;
    end
  end

endmodule : swr_reg_file

// ===== swr_top.sv
// How it works
// - mode 0: sample input on rising clock, launch output on falling
// - every byte travels most significant bit first, in and out
// - first byte holds a 3-bit opcode over a 5-bit address
// - opcodes: nop, control read, control write, addressed read, write
// - addresses 0 and 1 reach the wiper, 10h the control register
// - a write is chip select low, instruction, data, chip select high
// - writes land only at the rising edge of chip select
// - third read byte echoes instruction, fourth carries register data
// - control bit 1 picks push-pull (0) or open-drain (1) output
// - control bit 6 low means shutdown; it resets high
// - shutdown keeps the wiper code and leaves registers accessible
// - leaving shutdown returns the wiper to the stored code
// - output repeats input sixteen bits later for chained parts
// - every chained part commits at the same chip select rise
// - chained read: read pairs in one period, nop pairs in the next
// - chained read answer: 111b plus address, then the data byte
// - wiper register starts at 80h
// - deselected means the serial output is not driven
// - wiper code maps monotonically from low to high terminal
`timescale 1ns/1ps
module swr_top (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       spi_sck,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_sdi,
  output logic            spi_sdo_o,
  output logic            spi_sdo_oe,
  output logic [7:0]      wiper_tap,
  output logic            pot_shutdown,
  output logic            output_type_select
);

  // register file outputs (mclk domain)
  logic [7:0]              wiper_position;
  logic [7:0]              access_control;

  // link side state (spi_sck domain)
  logic                    frame_rst;
  logic [3:0]              bit_cnt_reg;
  logic [3:0]              bit_cnt_next;
  logic                    rx_started_reg;
  logic                    rx_started_next;
  logic [15:0]             in_sr_reg;
  logic [15:0]             in_sr_next;
  logic [15:0]             pair_reg;
  logic [15:0]             pair_next;
  logic                    pair_ok_reg;
  logic                    pair_ok_next;
  logic                    out_bit_reg;
  logic                    out_bit_next;
  logic                    tx_started_reg;
  logic                    tx_started_next;
  logic [15:0]             in_word;
  logic [15:0]             resp_word;
  logic [2:0]              in_opc;
  logic [4:0]              in_addr;
  logic [4:0]              echo_addr;

  // mclk side state
  logic                    cs_n_sync;
  logic                    tx_started_sync;
  logic                    out_bit_sync;
  swr_pkg::swr_state_e     state_reg;
  swr_pkg::swr_state_e     state_next;
  logic                    pend_read_reg;
  logic                    pend_read_next;
  logic [4:0]              pend_addr_reg;
  logic [4:0]              pend_addr_next;
  logic                    wr_en;
  logic                    wr_ctrl;
  logic [7:0]              wr_data;
  logic [2:0]              cmt_opc;
  logic [4:0]              cmt_addr;
  logic                    cmt_wiper;
  logic                    cmt_ctrl;
  logic                    sdo_bit;
  logic                    open_drain;
  logic                    spi_sdo_o_next;
  logic                    spi_sdo_oe_next;
  logic [7:0]              wiper_tap_next;
  logic                    pot_shutdown_next;
  logic                    output_type_select_next;

  // the slot counter, start flags and launched bit are held in reset whenever the part is deselected
  assign frame_rst = reset | spi_cs_n;

  // link clock domain

  // the answer for a chained read queued at the previous commit;
  // pend_* and the registers only change while chip select is high,
  // so they stand still for the whole frame that reads them
  always_comb begin
    resp_word = 16'h0000;
    if (pend_read_reg) begin
      resp_word = {swr_pkg::OP_CHAIN_TAG, pend_addr_reg,
                   swr_pkg::read_value(pend_addr_reg, wiper_position,
                                       access_control)};
    end
  end

  assign in_word = {in_sr_reg[14:0], spi_sdi};
  assign in_opc  = in_word[swr_pkg::OPC_MSB:swr_pkg::OPC_LSB];
  assign in_addr = in_word[swr_pkg::ADR_MSB:swr_pkg::ADR_LSB];

  // control read ignores the address field and always means 10h
  always_comb begin
    echo_addr = in_addr;
    if (in_opc == swr_pkg::OP_CTRL_RD) begin
      echo_addr = swr_pkg::ADDR_CTRL;
    end
  end

  // receive side: count slots, capture pairs, prime the answer
  always_comb begin
    bit_cnt_next    = bit_cnt_reg + 4'h1;
    rx_started_next = 1'b1;
    in_sr_next      = in_word;
    pair_next       = pair_reg;
    pair_ok_next    = pair_ok_reg;
    if (!rx_started_reg) begin
      in_sr_next = {resp_word[14:0], spi_sdi};
    end
    if (bit_cnt_reg == swr_pkg::LAST_SLOT) begin
      pair_next    = in_word;
      pair_ok_next = 1'b1;
      if (in_opc == swr_pkg::OP_CTRL_RD ||
          in_opc == swr_pkg::OP_ADDR_RD) begin
        in_sr_next = {in_word[15:8],
                      swr_pkg::read_value(echo_addr, wiper_position,
                                          access_control)};
      end
    end else if (bit_cnt_reg == 4'h0) begin
      pair_ok_next = 1'b0;
    end
  end

  always_ff @(posedge spi_sck or posedge frame_rst) begin
    if (frame_rst) begin
      bit_cnt_reg    <= 4'h0;
      rx_started_reg <= 1'b0;
    end else begin
      bit_cnt_reg    <= bit_cnt_next;
      rx_started_reg <= rx_started_next;
    end
  end

  // pair capture survives deselect so the commit can read it
  always_ff @(posedge spi_sck or posedge reset) begin
    if (reset) begin
      in_sr_reg   <= 16'h0000;
      pair_reg    <= 16'h0000;
      pair_ok_reg <= 1'b0;
    end else begin
      in_sr_reg   <= in_sr_next;
      pair_reg    <= pair_next;
      pair_ok_reg <= pair_ok_next;
    end
  end

  always_comb begin
    out_bit_next    = in_sr_reg[15];
    tx_started_next = 1'b1;
  end

  always_ff @(negedge spi_sck or posedge frame_rst) begin
    if (frame_rst) begin
      out_bit_reg    <= 1'b0;
      tx_started_reg <= 1'b0;
    end else begin
      out_bit_reg    <= out_bit_next;
      tx_started_reg <= tx_started_next;
    end
  end

  // mclk domain

  // chip select and the launched bit cross on two flops each
  swr_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h4)
  ) u_sync (
    .clk   (mclk),
    .reset (reset),
    .d     ({spi_cs_n, tx_started_reg, out_bit_reg}),
    .q     ({cs_n_sync, tx_started_sync, out_bit_sync})
  );

  // the rising chip select is the handshake for pair_reg: no link
  // edge arrives while it is high, so the word is stable to read
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      swr_pkg::ST_IDLE: begin
        if (!cs_n_sync) begin
          state_next = swr_pkg::ST_FRAME;
        end
      end
      swr_pkg::ST_FRAME: begin
        if (cs_n_sync) begin
          state_next = swr_pkg::ST_COMMIT;
        end
      end
      swr_pkg::ST_COMMIT: begin
        state_next = swr_pkg::ST_IDLE;
      end
      default: begin
        state_next = swr_pkg::ST_IDLE;
      end
    endcase
  end

  // decode the last whole pair of the frame
  assign cmt_opc   = pair_reg[swr_pkg::OPC_MSB:swr_pkg::OPC_LSB];
  assign cmt_addr  = pair_reg[swr_pkg::ADR_MSB:swr_pkg::ADR_LSB];
  assign cmt_wiper = (cmt_addr == swr_pkg::ADDR_WIPER_A) ||
                     (cmt_addr == swr_pkg::ADDR_WIPER_B);
  assign cmt_ctrl  = (cmt_addr == swr_pkg::ADDR_CTRL);

  // commit writes and queue reads; unknown opcodes fall to nop
  always_comb begin
    wr_en          = 1'b0;
    wr_ctrl        = 1'b0;
    wr_data        = pair_reg[7:0];
    pend_read_next = pend_read_reg;
    pend_addr_next = pend_addr_reg;
    if (state_reg == swr_pkg::ST_COMMIT) begin
      pend_read_next = 1'b0;
      if (pair_ok_reg) begin
        case (cmt_opc)
          swr_pkg::OP_CTRL_WR: begin
            wr_en   = 1'b1;
            wr_ctrl = 1'b1;
          end
          swr_pkg::OP_ADDR_WR: begin
            wr_en   = cmt_wiper | cmt_ctrl;
            wr_ctrl = cmt_ctrl;
          end
          swr_pkg::OP_CTRL_RD: begin
            pend_read_next = 1'b1;
            pend_addr_next = swr_pkg::ADDR_CTRL;
          end
          swr_pkg::OP_ADDR_RD: begin
            pend_read_next = cmt_wiper | cmt_ctrl;
            pend_addr_next = cmt_addr;
          end
          default: begin
            pend_read_next = 1'b0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_reg     <= swr_pkg::ST_IDLE;
      pend_read_reg <= 1'b0;
      pend_addr_reg <= 5'h00;
    end else begin
      state_reg     <= state_next;
      pend_read_reg <= pend_read_next;
      pend_addr_reg <= pend_addr_next;
    end
  end

  swr_reg_file u_regs (
    .mclk           (mclk),
    .reset          (reset),
    .wr_en          (wr_en),
    .wr_ctrl        (wr_ctrl),
    .wr_data        (wr_data),
    .wiper_position (wiper_position),
    .access_control (access_control)
  );

  // before the first falling link edge the pin shows the answer msb
  assign sdo_bit    = tx_started_sync ? out_bit_sync : resp_word[15];
  assign open_drain = access_control[swr_pkg::CTRL_OTYPE_BIT];

  // pin driver; costs about 12 ns of lag, well inside a bit time
  always_comb begin
    spi_sdo_o_next  = sdo_bit;
    spi_sdo_oe_next = !cs_n_sync;
    if (open_drain) begin
      spi_sdo_o_next  = 1'b0;
      spi_sdo_oe_next = !cs_n_sync && !sdo_bit;
    end
    if (cs_n_sync) begin
      spi_sdo_oe_next = 1'b0;
    end
  end

  // wiper and shutdown state toward the resistor array
  always_comb begin
    wiper_tap_next          = wiper_position;
    pot_shutdown_next       =
      !access_control[swr_pkg::CTRL_SHUTDOWN_CONTROL_N_BIT];
    output_type_select_next = open_drain;
  end

  // every output leaves from a flop
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      spi_sdo_o          <= 1'b0;
      spi_sdo_oe         <= 1'b0;
      wiper_tap          <= swr_pkg::WIPER_RESET;
      pot_shutdown       <= 1'b0;
      output_type_select <= 1'b0;
    end else begin
      spi_sdo_o          <= spi_sdo_o_next;
      spi_sdo_oe         <= spi_sdo_oe_next;
      wiper_tap          <= wiper_tap_next;
      pot_shutdown       <= pot_shutdown_next;
      output_type_select <= output_type_select_next;
    end
  end

endmodule : swr_top

// ===== swr_properties.sv
`timescale 1ns/1ps
module swr_properties (
  input wire logic       mclk,
  input wire logic       reset,
  input wire logic       spi_sck,
  input wire logic       spi_cs_n,
  input wire logic       spi_sdi,
  input wire logic       spi_sdo_o,
  input wire logic       spi_sdo_oe,
  input wire logic [7:0] wiper_tap,
  input wire logic       pot_shutdown,
  input wire logic       output_type_select
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_reset_vals: assert property ($fell(reset) |->
    wiper_tap == swr_pkg::WIPER_RESET && !pot_shutdown && !spi_sdo_oe)
    else $error("outputs not at reset values after reset");
  a_oe_off_idle: assert property (spi_cs_n [*6] |=> !spi_sdo_oe)
    else $error("serial output driven while deselected");
  a_oe_on_frame: assert property (
    !spi_cs_n [*8] ##0 !output_type_select |-> spi_sdo_oe)
    else $error("push-pull output not driven in frame");
  a_od_no_high: assert property (
    output_type_select && spi_sdo_oe |-> !spi_sdo_o)
    else $error("open-drain output driven high");
  a_sdo_at_fall: assert property ($changed(spi_sdo_o) |->
    !spi_sck && !$past(spi_sck, 2))
    else $error("serial output changed outside clock low phase");
  a_wiper_on_cs: assert property ($changed(wiper_tap) |->
    spi_cs_n && $past(spi_cs_n, 3) && !$past(spi_cs_n, 10))
    else $error("wiper changed outside commit window");
  a_no_early_tap: assert property (
    $rose(spi_cs_n) |-> $stable(wiper_tap) [*3])
    else $error("wiper changed too early after select rise");
  a_shutdown_control_n_commit: assert property ($changed(pot_shutdown) |->
    spi_cs_n && $past(spi_cs_n, 3) && !$past(spi_cs_n, 10))
    else $error("shutdown changed outside commit window");
  // output type changes only at commit
  a_otype_commit: assert property ($changed(output_type_select) |->
    $past(spi_cs_n, 3) && !$past(spi_cs_n, 10))
    else $error("output type changed outside commit window");
endmodule : swr_properties

// ===== swr_host.sv
`timescale 1ns/1ps
module swr_host (
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_sdi,
  input  wire logic sdo_line
);
  // host owns clock and select; both idle
  initial begin
    spi_sck  = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b0;
  end

  // one select period of n bits; clock stands still outside it
  task automatic xfer(input logic [31:0] tx, input int n,
                      output logic [31:0] rx);
    rx = 32'h0;
    spi_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      // msb first, changed while clock low
      spi_sdi = tx[i];
      #80;
      spi_sck = 1'b1;
      rx = {rx[30:0], sdo_line};
      #80;
      spi_sck = 1'b0;
    end
    #80;
    spi_cs_n = 1'b1;
    spi_sdi = ~spi_sdi; // stale level must not look valid
    #2000; // deselect time lets register side settle
  endtask : xfer
endmodule : swr_host

// ===== swr_tb.sv
`timescale 1ns/1ps
module testbench;
  logic        mclk;
  logic        reset;
  wire         spi_sck;
  wire         spi_cs_n;
  wire         spi_sdi;
  wire         sdo_line;
  logic        spi_sdo_o;
  logic        spi_sdo_oe;
  logic [7:0]  wiper_tap;
  logic        pot_shutdown;
  logic        output_type_select;
  logic        idle_pat = 1'b0;
  logic [7:0]  lfsr;
  logic [7:0]  d;
  logic [7:0]  y;
  logic [31:0] rx;
  logic [7:0]  obs_val;
  logic [7:0]  exp_q[$];
  string       name_q[$];
  logic [7:0]  ops[5] = '{8'h00, 8'h40, 8'ha0, 8'he0, 8'hc5};
  event        obs_ev;
  int          bad_count = 0;
  int          tests_run = 0;

  swr_top DUT (.mclk(mclk), .reset(reset), .spi_sck(spi_sck),
    .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo_o(spi_sdo_o),
    .spi_sdo_oe(spi_sdo_oe), .wiper_tap(wiper_tap),
    .pot_shutdown(pot_shutdown), .output_type_select(output_type_select));
  swr_host u_host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
    .spi_sdi(spi_sdi), .sdo_line(sdo_line));

  // released push-pull line wanders; open drain has a pull-up
  always @(posedge mclk) idle_pat <= ~idle_pat;
  assign sdo_line = spi_sdo_oe ? spi_sdo_o
                  : (output_type_select ? 1'b1 : idle_pat);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_next

  // note expectation, then hand the result to the watcher
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] v);
    name_q.push_back(nm);
    exp_q.push_back(e);
    obs_val = v;
    -> obs_ev;
    @(negedge mclk); // keeps link edges off the rising mclk edge
  endtask : chk

  task automatic wr(input logic [7:0] ins, input logic [7:0] dat);
    u_host.xfer({16'h0, ins, dat}, 16, rx);
  endtask : wr

  task automatic rd(input logic [7:0] ins, input logic [7:0] echo,
                    input logic [7:0] dat);
    lfsr = lfsr_next(lfsr);
    u_host.xfer({ins, lfsr, 8'h00, ~lfsr}, 32, rx);
    chk("echo byte", echo, rx[15:8]);
    chk("read data", dat, rx[7:0]);
  endtask : rd

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // watcher: oldest note against each result
  initial begin
    forever begin
      @(obs_ev);
      tests_run++;
      if (obs_val !== exp_q[0]) begin
        bad_count++;
        $display("unexpected %s: expected %h, seen %h", name_q[0],
                 exp_q[0], obs_val);
      end
      void'(exp_q.pop_front());
      void'(name_q.pop_front());
    end
  end

  // hang guard
  initial begin
    #380000;
    bad_count++;
    $display("unexpected run length: expected end, seen hang");
    finish_test();
  end

  initial begin
    reset = 1'b1;
    lfsr  = 8'h33;
    repeat (12) @(posedge mclk);
    #1 reset = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("wiper_tap", 8'h80, wiper_tap);
    chk("shutdown", 8'h00, {7'h0, pot_shutdown});
    chk("open drain", 8'h00, {7'h0, output_type_select});
    chk("sdo enable", 8'h00, {7'h0, spi_sdo_oe});
    rd(8'h3f, 8'h3f, 8'h40);
    $display("test reset values done");
    // both wiper aliases with random codes
    for (int a = 0; a < 2; a++) begin
      lfsr = lfsr_next(lfsr);
      d = lfsr;
      wr(8'hc0 | 8'(a), d);
      chk("wiper_tap", d, wiper_tap);
      rd(8'h80 | 8'(a), 8'h80 | 8'(a), d);
    end
    $display("test wiper access done");
    // ignored opcodes, unmapped address, frames cut short
    foreach (ops[i]) wr(ops[i], ~d);
    u_host.xfer({16'h0, 8'hc0, ~d} >> 1, 15, rx);
    u_host.xfer({8'h0, 8'hc0, ~d, 8'hc0}, 24, rx);
    chk("wiper_tap", d, wiper_tap);
    rd(8'h85, 8'h85, 8'h00);
    $display("test ignored traffic done");
    // control register, output type and shutdown
    wr(8'h7f, 8'hff);
    chk("open drain", 8'h01, {7'h0, output_type_select});
    rd(8'h90, 8'h90, 8'h42);
    wr(8'hd0, 8'h00);
    chk("shutdown", 8'h01, {7'h0, pot_shutdown});
    chk("open drain", 8'h00, {7'h0, output_type_select});
    lfsr = lfsr_next(lfsr);
    y = lfsr;
    wr(8'hc1, y);
    rd(8'h80, 8'h80, y);
    wr(8'h60, 8'h40);
    chk("wiper_tap", y, wiper_tap);
    chk("shutdown", 8'h00, {7'h0, pot_shutdown});
    $display("test control register done");
    // chained write then chained read
    u_host.xfer({8'hc0, d, 8'hc0, y ^ 8'h5a}, 32, rx);
    chk("chain out", 8'h00, rx[31:24]);
    chk("chain out", 8'hc0, rx[15:8]);
    chk("chain out", d, rx[7:0]);
    chk("wiper_tap", y ^ 8'h5a, wiper_tap);
    u_host.xfer({16'h0, 8'h81, lfsr}, 16, rx);
    u_host.xfer(32'h0, 16, rx);
    chk("chain tag", 8'he1, rx[15:8]);
    chk("chain data", y ^ 8'h5a, rx[7:0]);
    u_host.xfer({16'h0, 8'h20, lfsr}, 16, rx);
    u_host.xfer(32'h0, 16, rx);
    chk("chain tag", 8'hf0, rx[15:8]);
    chk("chain data", 8'h40, rx[7:0]);
    $display("test daisy chain done");
    finish_test();
  end
endmodule : testbench

bind swr_top swr_properties u_props (.mclk(mclk), .reset(reset),
  .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
  .spi_sdo_o(spi_sdo_o), .spi_sdo_oe(spi_sdo_oe), .wiper_tap(wiper_tap),
  .pot_shutdown(pot_shutdown), .output_type_select(output_type_select));
